// ### include/psm_pkg.sv
package psm_pkg;
    // processor top-level states
    typedef enum logic [2:0] {
        PSM_RESET,
        PSM_EXCEPT,
        PSM_EXEC,
        PSM_PDOWN,
        PSM_BUSREL
    } psm_state_t;

    // power-down sub-modes
    typedef enum logic [1:0] {
        PSM_PD_NONE,
        PSM_PD_SLEEP,
        PSM_PD_STANDBY,
        PSM_PD_HWSTBY
    } psm_pd_t;

    localparam int PSM_XLEN = 32;
    localparam logic [31:0] PSM_RESET_VECTOR = 32'hA000_0000;
    localparam logic [31:0] PSM_SR_RESET = 32'h7000_00F0;
    localparam int PSM_MD_BIT = 30;
    localparam logic [31:0] PSM_PC_STEP = 32'h0000_0002;
    localparam logic [1:0] PSM_RST_NONE = 2'h0;
    localparam logic [1:0] PSM_RST_POWER_ON = 2'h1;
    localparam logic [1:0] PSM_RST_MANUAL = 2'h2;
endpackage : psm_pkg

// ### hw/psm_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser per bit for asynchronous pins
module psm_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // first stage feeds only the second stage
            always_ff @(posedge clock)
            begin
                if (sys_rst)
                begin
                    meta_r[i] <= INIT[i];
                    sync_out[i] <= INIT[i];
                end
                else
                begin
                    meta_r[i] <= async_in[i];
                    sync_out[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule : psm_sync

// ### hw/psm_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - reset pin low forces reset state from any state
// - bus request level during reset picks power-on (high) or manual (low)
// - power-on reset initialises cpu state and bus controller registers
// - manual reset initialises cpu state but keeps bus controller, refresh continues
// - leaving reset, fetch starts at fixed handler address
// - exception or interrupt saves pc and status word before branching
// - handler address is vector base plus event vector offset
// - halt instruction or hardware-standby pin enters power-down
// - power-down has sleep, standby and hardware-standby sub-modes
// - external bus request moves device to bus-released state from execution or sleep power-down only
// - execution state steps instructions in program order
// - privilege bit 0 means user, 1 means privileged
// - reset or exception entry sets privilege bit to 1
// - end of exception handling clears privilege bit to 0
// - privileged-only accesses are refused in user mode
module psm_ctrl #(
    parameter bit HWSTBY_EN = 1'h1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic bus_request_pin_n,
    input wire logic hardware_standby_pin_n,
    input wire logic exc_req,
    input wire logic [31:0] exc_vec_offset,
    input wire logic [31:0] vector_base,
    input wire logic exc_return,
    input wire logic sleep_exec,
    input wire logic standby_sel,
    input wire logic wake_req,
    input wire logic priv_access,
    input wire logic [31:0] status_wr_data,
    input wire logic status_wr,
    output psm_pkg::psm_state_t state,
    output psm_pkg::psm_pd_t pd_mode,
    output logic [1:0] reset_kind,
    output logic bsc_init,
    output logic bus_grant_n,
    output logic [31:0] program_counter,
    output logic [31:0] status_word,
    output logic [31:0] saved_program_counter,
    output logic [31:0] saved_status_word,
    output logic privilege_mode_bit,
    output logic access_refused
);
    logic reset_s;
    logic bus_request_pin_s;
    logic hwstby_s;
    logic [2:0] sync_q;

    psm_pkg::psm_state_t state_r, state_nxt, resume_r;
    psm_pkg::psm_pd_t pd_r, pd_nxt;
    logic [1:0] kind_r;
    logic bsc_init_r;
    logic grant_n_r;
    logic [31:0] pc_r, pc_nxt;
    logic [31:0] sr_r, sr_nxt;
    logic [31:0] spc_r;
    logic [31:0] ssr_r;
    logic refused_r;

    // pins are asynchronous to the core clock
    psm_sync #(.WIDTH(3), .INIT(3'h7)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({reset_pin_n, bus_request_pin_n, hardware_standby_pin_n}),
        .sync_out(sync_q)
    );

    // decoded pin levels
    assign reset_s = ~sync_q[2];
    assign bus_request_pin_s = ~sync_q[1];
    assign hwstby_s = HWSTBY_EN & ~sync_q[0];

    // event qualifiers
    wire take_exc = (state_r == psm_pkg::PSM_EXEC) && exc_req;
    wire md_now = sr_r[psm_pkg::PSM_MD_BIT];
    wire [31:0] handler_addr = vector_base + exc_vec_offset;
    wire enter_pd = (state_r == psm_pkg::PSM_EXEC) && (sleep_exec || hwstby_s);
    wire leave_pd = (state_r == psm_pkg::PSM_PDOWN) && !hwstby_s && (wake_req || exc_req)
                    && (pd_r != psm_pkg::PSM_PD_HWSTBY || !hwstby_s);
    wire can_release = (state_r == psm_pkg::PSM_EXEC) || (state_r == psm_pkg::PSM_PDOWN
                       && pd_r == psm_pkg::PSM_PD_SLEEP);

    // next state selection
    always_comb
    begin
        state_nxt = state_r;
        pd_nxt = pd_r;
        if (reset_s)
        begin
            state_nxt = psm_pkg::PSM_RESET;
            pd_nxt = psm_pkg::PSM_PD_NONE;
        end
        else
        begin
            unique case (state_r)
                psm_pkg::PSM_RESET:
                begin
                    state_nxt = psm_pkg::PSM_EXCEPT;
                end
                psm_pkg::PSM_EXCEPT:
                begin
                    state_nxt = psm_pkg::PSM_EXEC;
                end
                psm_pkg::PSM_EXEC:
                begin
                    // bus request wins over new work
                    if (bus_request_pin_s)
                        state_nxt = psm_pkg::PSM_BUSREL;
                    else if (take_exc)
                        state_nxt = psm_pkg::PSM_EXCEPT;
                    else if (enter_pd)
                    begin
                        state_nxt = psm_pkg::PSM_PDOWN;
                        if (hwstby_s)
                            pd_nxt = psm_pkg::PSM_PD_HWSTBY;
                        else if (standby_sel)
                            pd_nxt = psm_pkg::PSM_PD_STANDBY;
                        else
                            pd_nxt = psm_pkg::PSM_PD_SLEEP;
                    end
                end
                psm_pkg::PSM_PDOWN:
                begin
                    if (bus_request_pin_s && can_release)
                        state_nxt = psm_pkg::PSM_BUSREL;
                    else if (hwstby_s)
                        pd_nxt = psm_pkg::PSM_PD_HWSTBY;
                    else if (pd_r == psm_pkg::PSM_PD_HWSTBY)
                    begin
                        // hardware standby only ends through reset
                        pd_nxt = pd_r;
                    end
                    else if (leave_pd)
                    begin
                        // a waking exception is taken from execution, where its context is saved
                        state_nxt = psm_pkg::PSM_EXEC;
                        pd_nxt = psm_pkg::PSM_PD_NONE;
                    end
                end
                psm_pkg::PSM_BUSREL:
                begin
                    if (!bus_request_pin_s)
                        state_nxt = resume_r;
                end
            endcase
        end
    end

    // program counter and status word update
    always_comb
    begin
        pc_nxt = pc_r;
        sr_nxt = sr_r;
        if (state_r == psm_pkg::PSM_RESET)
        begin
            pc_nxt = psm_pkg::PSM_RESET_VECTOR;
            sr_nxt = psm_pkg::PSM_SR_RESET;
            sr_nxt[psm_pkg::PSM_MD_BIT] = 1'h1;
        end
        else if (take_exc && !bus_request_pin_s)
        begin
            pc_nxt = handler_addr;
            sr_nxt[psm_pkg::PSM_MD_BIT] = 1'h1;
        end
        else if (state_r == psm_pkg::PSM_EXEC && exc_return && md_now)
        begin
            pc_nxt = spc_r;
            sr_nxt = ssr_r;
            sr_nxt[psm_pkg::PSM_MD_BIT] = 1'h0;
        end
        else if (state_r == psm_pkg::PSM_EXEC && !bus_request_pin_s && !enter_pd)
        begin
            pc_nxt = pc_r + psm_pkg::PSM_PC_STEP;
            if (status_wr && md_now)
                sr_nxt = status_wr_data;
        end
    end

    // state registers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_r <= psm_pkg::PSM_RESET;
            pd_r <= psm_pkg::PSM_PD_NONE;
            resume_r <= psm_pkg::PSM_EXEC;
        end
        else
        begin
            state_r <= state_nxt;
            pd_r <= pd_nxt;
            if (state_r != psm_pkg::PSM_BUSREL && state_nxt == psm_pkg::PSM_BUSREL)
                resume_r <= state_r;
        end
    end

    // reset kind is latched while reset is held
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            kind_r <= psm_pkg::PSM_RST_POWER_ON;
            bsc_init_r <= 1'h1;
        end
        else if (reset_s)
        begin
            kind_r <= bus_request_pin_s ? psm_pkg::PSM_RST_MANUAL : psm_pkg::PSM_RST_POWER_ON;
            // bus controller init only on power-on
            bsc_init_r <= !bus_request_pin_s;
        end
        else
        begin
            bsc_init_r <= 1'h0;
        end
    end

    // cpu registers, cleared on both reset kinds
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pc_r <= psm_pkg::PSM_RESET_VECTOR;
            sr_r <= psm_pkg::PSM_SR_RESET;
            spc_r <= '0;
            ssr_r <= '0;
        end
        else
        begin
            pc_r <= pc_nxt;
            sr_r <= sr_nxt;
            // saved context cleared by either reset kind
            if (state_r == psm_pkg::PSM_RESET)
            begin
                spc_r <= '0;
                ssr_r <= '0;
            end
            else if (take_exc && !bus_request_pin_s)
            begin
                spc_r <= pc_r;
                ssr_r <= sr_r;
            end
        end
    end

    // bus grant and privilege check outputs
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            grant_n_r <= 1'h1;
            refused_r <= 1'h0;
        end
        else
        begin
            grant_n_r <= (state_nxt != psm_pkg::PSM_BUSREL);
            // refuse in user mode, bit 0 is user
            refused_r <= (priv_access || status_wr) && !md_now;
        end
    end

    assign state = state_r;
    assign pd_mode = pd_r;
    assign reset_kind = kind_r;
    assign bsc_init = bsc_init_r;
    assign bus_grant_n = grant_n_r;
    assign program_counter = pc_r;
    assign status_word = sr_r;
    assign saved_program_counter = spc_r;
    assign saved_status_word = ssr_r;
    assign privilege_mode_bit = sr_r[psm_pkg::PSM_MD_BIT];
    assign access_refused = refused_r;
endmodule : psm_ctrl

// ### testbench/psm_chk.sv
`timescale 1ns/1ps
// watches the controller ports; pin paths get slack for the two-flop synchroniser
module psm_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic bus_request_pin_n,
    input wire logic exc_req,
    input wire logic [31:0] exc_vec_offset,
    input wire logic [31:0] vector_base,
    input wire logic exc_return,
    input wire logic priv_access,
    input wire logic status_wr,
    input wire psm_pkg::psm_state_t state,
    input wire logic [31:0] program_counter,
    input wire logic [31:0] status_word,
    input wire logic [31:0] saved_program_counter,
    input wire logic [31:0] saved_status_word,
    input wire logic privilege_mode_bit,
    input wire logic access_refused,
    input wire logic bus_grant_n
);
    localparam psm_pkg::psm_state_t EX = psm_pkg::PSM_EXEC;
    localparam psm_pkg::psm_state_t XC = psm_pkg::PSM_EXCEPT;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // an exception taken out of the execution state
    sequence exc_taken;
        $past(state) == EX ##0 state == XC;
    endsequence
    // a fresh bus request seen while executing; with reset low it only selects the reset kind
    sequence req_in_exec;
        $fell(bus_request_pin_n) && reset_pin_n ##0 state == EX;
    endsequence
    chk_save_context:
        assert property (exc_taken |-> saved_program_counter == $past(program_counter)
            && saved_status_word == $past(status_word)) else $error("context not saved");
    chk_handler_addr:
        assert property (exc_taken |-> program_counter == $past(vector_base) + $past(exc_vec_offset))
            else $error("handler address wrong");
    chk_reset_leave:
        assert property ($past(state) == psm_pkg::PSM_RESET ##0 state == XC |->
            program_counter == psm_pkg::PSM_RESET_VECTOR && privilege_mode_bit) else $error("reset entry wrong");
    chk_mode_bit_map:
        assert property (privilege_mode_bit == status_word[psm_pkg::PSM_MD_BIT]) else $error("mode bit apart");
    chk_exec_step:
        assert property ($past(state) == EX && state == EX && !$past(exc_return) |->
            program_counter == $past(program_counter) + psm_pkg::PSM_PC_STEP) else $error("pc step wrong");
    chk_mode_clear:
        assert property (exc_return && privilege_mode_bit && state == EX && !exc_req && bus_request_pin_n
            |=> !privilege_mode_bit) else $error("mode bit not cleared");
    chk_user_refuse:
        assert property ((priv_access || status_wr) && !privilege_mode_bit |=> access_refused)
            else $error("access not refused");
    chk_bus_handover:
        assert property (req_in_exec |-> ##[1:4] (state == psm_pkg::PSM_BUSREL && !bus_grant_n))
            else $error("bus not released");
    chk_pin_reset:
        assert property (!reset_pin_n [*3] |-> ##1 state == psm_pkg::PSM_RESET) else $error("reset pin ignored");
    chk_priv_allow:
        assert property ((priv_access || status_wr) && privilege_mode_bit |=> !access_refused)
            else $error("privileged access refused");
endmodule : psm_chk

// ### testbench/psm_ext_sys.sv
`timescale 1ns/1ps
// outside system: pins follow commands set by the bench just after a falling edge
module psm_ext_sys (
    input wire logic rst_cmd,
    input wire logic manual_sel,
    input wire logic bus_request_pin_cmd,
    input wire logic hwstby_cmd,
    output logic reset_pin_n,
    output logic bus_request_pin_n,
    output logic hardware_standby_pin_n
);
    assign bus_request_pin_n = !(bus_request_pin_cmd || (rst_cmd && manual_sel));
    assign reset_pin_n = !rst_cmd;
    assign hardware_standby_pin_n = !hwstby_cmd;
endmodule : psm_ext_sys

// ### testbench/test_processor_state_mode_control.sv
`timescale 1ns/1ps
module test_processor_state_mode_control;
    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    logic rst_cmd = 1'h0, manual_sel = 1'h0, bus_request_pin_cmd = 1'h0, hwstby_cmd = 1'h0, exc_req = 1'h0;
    logic exc_return = 1'h0, sleep_exec = 1'h0, standby_sel = 1'h0, wake_req = 1'h0;
    logic priv_access = 1'h0, status_wr = 1'h0;
    logic [31:0] vector_base = 32'h8C00_0000, exc_vec_offset = 32'h0000_0600, status_wr_data = 32'hFFFF_FFFF;
    logic reset_pin_n, bus_request_pin_n, hardware_standby_pin_n;
    psm_pkg::psm_state_t state;
    psm_pkg::psm_pd_t pd_mode;
    logic [1:0] reset_kind;
    logic bsc_init, bus_grant_n, privilege_mode_bit, access_refused;
    logic [31:0] program_counter, status_word, saved_program_counter, saved_status_word;
    int failures = 0;
    int cmp_count = 0;
    psm_ext_sys ext (.rst_cmd(rst_cmd), .manual_sel(manual_sel), .bus_request_pin_cmd(bus_request_pin_cmd), .hwstby_cmd(hwstby_cmd),
        .reset_pin_n(reset_pin_n), .bus_request_pin_n(bus_request_pin_n),
        .hardware_standby_pin_n(hardware_standby_pin_n));
    psm_ctrl dut (.clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
        .bus_request_pin_n(bus_request_pin_n), .hardware_standby_pin_n(hardware_standby_pin_n),
        .exc_req(exc_req), .exc_vec_offset(exc_vec_offset), .vector_base(vector_base), .exc_return(exc_return),
        .sleep_exec(sleep_exec), .standby_sel(standby_sel), .wake_req(wake_req), .priv_access(priv_access),
        .status_wr_data(status_wr_data), .status_wr(status_wr), .state(state), .pd_mode(pd_mode),
        .reset_kind(reset_kind), .bsc_init(bsc_init), .bus_grant_n(bus_grant_n),
        .program_counter(program_counter), .status_word(status_word),
        .saved_program_counter(saved_program_counter), .saved_status_word(saved_status_word),
        .privilege_mode_bit(privilege_mode_bit), .access_refused(access_refused));
    // 125 MHz core clock
    initial forever #4 clock = ~clock;
    task automatic conclude();
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    // bounded wait; pins add two synchroniser cycles to every path
    task automatic wait_state(input psm_pkg::psm_state_t st);
        for (int i = 0; i < 10 && state !== st; i++) tick(1);
        if (state !== st)
        begin
            check(state, st);
            conclude();
        end
    endtask : wait_state
    task automatic pin_reset(input logic manual);
        manual_sel = manual;
        rst_cmd = 1'h1;
        wait_state(psm_pkg::PSM_RESET);
        tick(3);
        check(reset_kind, manual ? psm_pkg::PSM_RST_MANUAL : psm_pkg::PSM_RST_POWER_ON);
        check(bsc_init, !manual);
        rst_cmd = 1'h0;
        manual_sel = 1'h0;
        wait_state(psm_pkg::PSM_EXEC);
        check(program_counter, psm_pkg::PSM_RESET_VECTOR);
        check(privilege_mode_bit, 1'h1);
    endtask : pin_reset
    task automatic exc_cycle();
        logic [31:0] pc0;
        logic [31:0] sr0;
        pc0 = program_counter;
        sr0 = status_word;
        exc_req = 1'h1;
        tick(1);
        exc_req = 1'h0;
        check(program_counter, 32'h8C00_0600);
        check(saved_program_counter, pc0);
        check(saved_status_word, sr0);
        check(privilege_mode_bit, 1'h1);
        wait_state(psm_pkg::PSM_EXEC);
        tick(1);
        check(program_counter, 32'h8C00_0600 + psm_pkg::PSM_PC_STEP);
    endtask : exc_cycle
    // privileged status write lands, then drop to user mode and try privileged accesses
    task automatic user_mode();
        logic [31:0] sr0;
        status_wr = 1'h1;
        tick(1);
        status_wr = 1'h0;
        check(status_word, status_wr_data);
        check(access_refused, 1'h0);
        exc_return = 1'h1;
        tick(1);
        exc_return = 1'h0;
        check(privilege_mode_bit, 1'h0);
        sr0 = status_word;
        priv_access = 1'h1;
        tick(1);
        priv_access = 1'h0;
        check(access_refused, 1'h1);
        status_wr = 1'h1;
        tick(1);
        status_wr = 1'h0;
        check(status_word, sr0);
        check(access_refused, 1'h1);
    endtask : user_mode
    task automatic halt(input logic stby);
        standby_sel = stby;
        sleep_exec = 1'h1;
        tick(1);
        sleep_exec = 1'h0;
        standby_sel = 1'h0;
        check(state, psm_pkg::PSM_PDOWN);
        check(pd_mode, stby ? psm_pkg::PSM_PD_STANDBY : psm_pkg::PSM_PD_SLEEP);
        wake_req = 1'h1;
        wait_state(psm_pkg::PSM_EXEC);
        wake_req = 1'h0;
        check(pd_mode, psm_pkg::PSM_PD_NONE);
    endtask : halt
    // release from sleep must come back to sleep, not to execution
    task automatic bus_release(input logic from_sleep);
        sleep_exec = from_sleep;
        tick(1);
        sleep_exec = 1'h0;
        bus_request_pin_cmd = 1'h1;
        wait_state(psm_pkg::PSM_BUSREL);
        check(bus_grant_n, 1'h0);
        bus_request_pin_cmd = 1'h0;
        wait_state(from_sleep ? psm_pkg::PSM_PDOWN : psm_pkg::PSM_EXEC);
        check(bus_grant_n, 1'h1);
        // only a sleeping core needs waking; an executing one is already back
        if (from_sleep)
        begin
            check(pd_mode, psm_pkg::PSM_PD_SLEEP);
            wake_req = 1'h1;
            wait_state(psm_pkg::PSM_EXEC);
            wake_req = 1'h0;
        end
    endtask : bus_release
    task automatic hw_standby();
        hwstby_cmd = 1'h1;
        wait_state(psm_pkg::PSM_PDOWN);
        check(pd_mode, psm_pkg::PSM_PD_HWSTBY);
        hwstby_cmd = 1'h0;
        wake_req = 1'h1;
        tick(5);
        wake_req = 1'h0;
        check(state, psm_pkg::PSM_PDOWN);
        pin_reset(1'h0);
    endtask : hw_standby
    initial
    begin
        tick(3);
        sys_rst = 1'h0;
        wait_state(psm_pkg::PSM_EXEC);
        pin_reset(1'h0);
        pin_reset(1'h1);
        exc_cycle();
        user_mode();
        exc_cycle();
        halt(1'h0);
        halt(1'h1);
        bus_release(1'h0);
        bus_release(1'h1);
        hw_standby();
        conclude();
    end
endmodule : test_processor_state_mode_control
bind psm_ctrl psm_chk chk_i (.clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .bus_request_pin_n(bus_request_pin_n),
    .exc_req(exc_req), .exc_vec_offset(exc_vec_offset), .vector_base(vector_base), .exc_return(exc_return),
    .priv_access(priv_access), .status_wr(status_wr), .state(state), .program_counter(program_counter),
    .status_word(status_word), .saved_program_counter(saved_program_counter),
    .saved_status_word(saved_status_word), .privilege_mode_bit(privilege_mode_bit),
    .access_refused(access_refused), .bus_grant_n(bus_grant_n));
